// >>> design/sbrg_consts.svh
// Constants of the serial rate generator: addresses, bit positions, counts.
`ifndef SBRG_CONSTS_SVH
`define SBRG_CONSTS_SVH
`define SBRG_ADDR_CTRL 8'h00
`define SBRG_ADDR_DLO 8'h04
`define SBRG_ADDR_DHI 8'h08
`define SBRG_ADDR_TCS 8'h0C
`define SBRG_ADDR_STS 8'h10
`define SBRG_ADDR_MSK 8'h14
`define SBRG_BIT_ABD 0
`define SBRG_BIT_WAKE 1
`define SBRG_BIT_WIDE 3
`define SBRG_BIT_IDLE 6
`define SBRG_BIT_HS 2
`define SBRG_BIT_SYNC 4
`define SBRG_EV_WAKE 0
`define SBRG_EV_ABD 1
`define SBRG_PRE_64 6'h3F
`define SBRG_PRE_16 6'h0F
`define SBRG_PRE_4 6'h03
`define SBRG_RST_DIV 8'h00
`define SBRG_CNT_MAX 16'hFFFF
`endif

// >>> design/sbrg_pkg.sv
// Types of the serial rate generator.
package sbrg_pkg;
   typedef enum logic [2:0] {
      SBRG_ABD_IDLE = 3'h1,
      SBRG_ABD_WAIT = 3'h2,
      SBRG_ABD_MEAS = 3'h4
   } sbrg_abd_type;

   typedef struct packed {
      logic s1;
      logic s2;
   } sbrg_sync_type;

   typedef struct packed {
      logic wide;
      logic wake_en;
      logic abd_en;
      logic high_speed;
      logic sync_mode;
      logic [7:0] div_lo;
      logic [7:0] div_hi;
      logic [5:0] pre;
      logic [15:0] cnt;
      logic [15:0] abd_cnt;
      sbrg_abd_type abd;
      logic rx_prev;
      logic [1:0] irq_sts;
      logic [1:0] irq_msk;
      logic irq;
      logic tick;
      logic ap_valid;
      logic ap_write;
      logic [7:0] ap_addr;
      logic [31:0] rdata;
      logic hready;
      logic [22:0] gap;
      logic seen;
      logic chg;
   } sbrg_state_type;
endpackage : sbrg_pkg

// >>> design/sbrg_sync.sv
// Two flip-flop synchroniser for the receive pin.
`timescale 1ns/1ps
module sbrg_sync (
   input wire logic clk_in,
   input wire logic rstn_in,
   input wire logic d_in,
   output logic q_out
);
   sbrg_pkg::sbrg_sync_type st_ff;
   sbrg_pkg::sbrg_sync_type nxt_st;

   // The first stage feeds only the second stage.
   always_comb begin
      nxt_st.s1 = d_in;
      nxt_st.s2 = st_ff.s1;
   end

   // Idle line is high, so both stages reset high.
   always_ff @(posedge clk_in) begin
      if (!rstn_in) begin
         st_ff <= 2'h3;
      end else begin
         st_ff <= nxt_st;
      end
   end

   assign q_out = st_ff.s2;
endmodule : sbrg_sync

// >>> design/sbrg_top.sv
// Serial port rate generator with wake-on-edge, auto-rate detect and AHB-Lite registers.
// Function
// - In asynchronous mode with wake enabled, a falling receive edge sets the wake status flag and clears the wake enable.
// - One rate generator times both asynchronous and synchronous operation.
// - The timer is 8 bits after reset and uses the full 16-bit divisor when wide mode is set.
// - The period comes from the divisor pair, high byte on top.
// - In asynchronous mode the multiplier depends on high-speed and wide selects together.
// - In synchronous mode high-speed is ignored and the multiplier is four.
// - A write to either divisor byte clears the rate timer at once.
// - Rates are clock/64(n+1) async 8-bit, clock/16(n+1) async 16-bit (each four times faster with high-speed), clock/4(n+1) sync.
`timescale 1ns/1ps
`include "sbrg_consts.svh"
module sbrg_top (
   input wire logic REF_CLK_IN,
   input wire logic RSTN_IN,
   input wire logic HSEL_IN,
   input wire logic [31:0] HADDR_IN,
   input wire logic [1:0] HTRANS_IN,
   input wire logic HWRITE_IN,
   input wire logic [2:0] HSIZE_IN,
   input wire logic [31:0] HWDATA_IN,
   input wire logic HREADY_IN,
   input wire logic RX_IN,
   output logic [31:0] HRDATA_OUT,
   output logic HREADYOUT_OUT,
   output logic HRESP_OUT,
   output logic IRQ_OUT,
   output logic BIT_TICK_OUT
);
   sbrg_pkg::sbrg_state_type st_ff;
   sbrg_pkg::sbrg_state_type nxt_st;
   logic rx_sync;
   logic wr_now;
   logic fall;
   logic rise;
   logic step;
   logic div_wr;
   logic ap_take;
   logic [1:0] sts_set;
   logic [1:0] sts_clr;
   logic [15:0] lim;
   logic [15:0] abd_n;

   // multiplier values
   // Prescaler end value; one prescaler pass is the multiplier in clocks.
   // Synchronous mode is decided first, so the high-speed select can never reach it.
   function automatic logic [5:0] pre_max(input logic sync_mode, input logic wide,
                                          input logic hs);
      if (sync_mode) begin
         pre_max = `SBRG_PRE_4;
      end else if (wide && hs) begin
         pre_max = `SBRG_PRE_4;
      end else if (wide || hs) begin
         pre_max = `SBRG_PRE_16;
      end else begin
         pre_max = `SBRG_PRE_64;
      end
   endfunction : pre_max

   // narrow limit
   // Timer limit; narrow mode sees only the low byte.
   // A stale high byte is harmless in narrow mode, because the timer limit does not use it there.
   function automatic logic [15:0] limit(input logic wide, input logic [7:0] hi,
                                         input logic [7:0] lo);
      limit = wide ? {hi, lo} : {8'h00, lo};
   endfunction : limit

   // Receive pin passes two flip-flops before any logic.
   sbrg_sync u_rx_sync (
      .clk_in(REF_CLK_IN),
      .rstn_in(RSTN_IN),
      .d_in(RX_IN),
      .q_out(rx_sync)
   );

   // Next-state logic for the whole block.
   always_comb begin
      nxt_st = st_ff;
      nxt_st.tick = 1'b0;
      wr_now = st_ff.ap_valid && st_ff.ap_write;
      fall = st_ff.rx_prev && !rx_sync;
      rise = !st_ff.rx_prev && rx_sync;
      sts_set = 2'h0;
      sts_clr = 2'h0;
      div_wr = 1'b0;
      ap_take = HSEL_IN && HTRANS_IN[1] && HREADY_IN;
      nxt_st.rx_prev = rx_sync;
      abd_n = (st_ff.abd_cnt == 16'h0000) ? 16'h0000 : st_ff.abd_cnt - 16'h0001;
      // Register writes land in the data phase.
      if (wr_now) begin
         if (st_ff.ap_addr == `SBRG_ADDR_CTRL) begin
            nxt_st.wide = HWDATA_IN[`SBRG_BIT_WIDE];
            nxt_st.wake_en = HWDATA_IN[`SBRG_BIT_WAKE];
            nxt_st.abd_en = HWDATA_IN[`SBRG_BIT_ABD];
         end else if (st_ff.ap_addr == `SBRG_ADDR_DLO) begin
            nxt_st.div_lo = HWDATA_IN[7:0];
            div_wr = 1'b1;
         end else if (st_ff.ap_addr == `SBRG_ADDR_DHI) begin
            nxt_st.div_hi = HWDATA_IN[7:0];
            div_wr = 1'b1;
         end else if (st_ff.ap_addr == `SBRG_ADDR_TCS) begin
            nxt_st.high_speed = HWDATA_IN[`SBRG_BIT_HS];
            nxt_st.sync_mode = HWDATA_IN[`SBRG_BIT_SYNC];
         end else if (st_ff.ap_addr == `SBRG_ADDR_STS) begin
            sts_clr = HWDATA_IN[1:0];
         end else if (st_ff.ap_addr == `SBRG_ADDR_MSK) begin
            nxt_st.irq_msk = HWDATA_IN[1:0];
         end
      end
      // multiplier select
      // Greater-or-equal compares let a mode change wrap at once instead of counting round.
      step = st_ff.pre >= pre_max(st_ff.sync_mode, st_ff.wide, st_ff.high_speed);
      nxt_st.pre = step ? 6'h00 : st_ff.pre + 6'h01;
      lim = limit(st_ff.wide, st_ff.div_hi, st_ff.div_lo);
      if (step) begin
         if (st_ff.cnt >= lim) begin
            nxt_st.cnt = 16'h0000;
            nxt_st.tick = 1'b1;
         end else begin
            nxt_st.cnt = st_ff.cnt + 16'h0001;
         end
      end
      if (div_wr) begin
         nxt_st.cnt = 16'h0000;
         nxt_st.pre = 6'h00;
      end
      if (st_ff.wake_en && !st_ff.sync_mode && fall) begin
         nxt_st.wake_en = 1'b0;
         sts_set[`SBRG_EV_WAKE] = 1'b1;
      end
      // auto-rate detect sequence
      // The low time of the start bit is counted in timer steps, which gives n+1 directly.
      unique case (st_ff.abd)
         sbrg_pkg::SBRG_ABD_IDLE: begin
            if (st_ff.abd_en && !st_ff.sync_mode) begin
               nxt_st.abd = sbrg_pkg::SBRG_ABD_WAIT;
            end
         end
         sbrg_pkg::SBRG_ABD_WAIT: begin
            if (!nxt_st.abd_en || st_ff.sync_mode) begin
               nxt_st.abd = sbrg_pkg::SBRG_ABD_IDLE;
            end else if (fall) begin
               nxt_st.abd = sbrg_pkg::SBRG_ABD_MEAS;
               nxt_st.abd_cnt = 16'h0000;
               nxt_st.pre = 6'h00;
            end
         end
         sbrg_pkg::SBRG_ABD_MEAS: begin
            if (!nxt_st.abd_en || st_ff.sync_mode) begin
               nxt_st.abd = sbrg_pkg::SBRG_ABD_IDLE;
            end else if (rise) begin
               nxt_st.abd = sbrg_pkg::SBRG_ABD_IDLE;
               nxt_st.div_lo = abd_n[7:0];
               if (st_ff.wide) begin
                  nxt_st.div_hi = abd_n[15:8];
               end
               nxt_st.cnt = 16'h0000;
               nxt_st.pre = 6'h00;
               nxt_st.abd_en = 1'b0;
               sts_set[`SBRG_EV_ABD] = 1'b1;
            end else if (step && st_ff.abd_cnt != `SBRG_CNT_MAX) begin
               nxt_st.abd_cnt = st_ff.abd_cnt + 16'h0001;
            end
         end
      endcase
      // A set in the same cycle as a clear wins, so no event is lost.
      nxt_st.irq_sts = (st_ff.irq_sts & ~sts_clr) | sts_set;
      nxt_st.irq = |(nxt_st.irq_sts & nxt_st.irq_msk);
      // Address phase capture; read data come from post-write values to avoid stale reads.
      nxt_st.ap_valid = ap_take;
      nxt_st.ap_write = HWRITE_IN;
      nxt_st.ap_addr = HADDR_IN[7:0];
      // Zero wait states, so the slave never stretches a transfer.
      nxt_st.hready = 1'b1;
      nxt_st.rdata = 32'h0000_0000;
      if (ap_take && !HWRITE_IN) begin
         if (HADDR_IN[7:0] == `SBRG_ADDR_CTRL) begin
            nxt_st.rdata[`SBRG_BIT_IDLE] = (nxt_st.abd != sbrg_pkg::SBRG_ABD_MEAS)
                                           && nxt_st.rx_prev;
            nxt_st.rdata[`SBRG_BIT_WIDE] = nxt_st.wide;
            nxt_st.rdata[`SBRG_BIT_WAKE] = nxt_st.wake_en;
            nxt_st.rdata[`SBRG_BIT_ABD] = nxt_st.abd_en;
         end else if (HADDR_IN[7:0] == `SBRG_ADDR_DLO) begin
            nxt_st.rdata[7:0] = nxt_st.div_lo;
         end else if (HADDR_IN[7:0] == `SBRG_ADDR_DHI) begin
            nxt_st.rdata[7:0] = nxt_st.div_hi;
         end else if (HADDR_IN[7:0] == `SBRG_ADDR_TCS) begin
            nxt_st.rdata[`SBRG_BIT_HS] = nxt_st.high_speed;
            nxt_st.rdata[`SBRG_BIT_SYNC] = nxt_st.sync_mode;
         end else if (HADDR_IN[7:0] == `SBRG_ADDR_STS) begin
            nxt_st.rdata[1:0] = nxt_st.irq_sts;
         end else if (HADDR_IN[7:0] == `SBRG_ADDR_MSK) begin
            nxt_st.rdata[1:0] = nxt_st.irq_msk;
         end
      end
      // Spacing monitor between ticks, read only by the checks below.
      nxt_st.gap = st_ff.gap + 23'h000001;
      nxt_st.chg = st_ff.chg || wr_now || (st_ff.abd != sbrg_pkg::SBRG_ABD_IDLE);
      if (st_ff.tick) begin
         nxt_st.gap = 23'h000001;
         nxt_st.seen = 1'b1;
         nxt_st.chg = wr_now;
      end
   end

   always_ff @(posedge REF_CLK_IN) begin
      if (!RSTN_IN) begin
         st_ff <= '0;
         st_ff.div_lo <= `SBRG_RST_DIV;
         st_ff.div_hi <= `SBRG_RST_DIV;
         st_ff.abd <= sbrg_pkg::SBRG_ABD_IDLE;
         st_ff.rx_prev <= 1'b1;
         st_ff.hready <= 1'b1;
         st_ff.chg <= 1'b1;
      end else begin
         st_ff <= nxt_st;
      end
   end

   // All outputs but HRESP_OUT, which is tied low, are taken straight from the registered state.
   assign HRDATA_OUT = st_ff.rdata;
   assign HREADYOUT_OUT = st_ff.hready;
   assign HRESP_OUT = 1'b0;
   assign IRQ_OUT = st_ff.irq;
   assign BIT_TICK_OUT = st_ff.tick;

   default clocking cb @(posedge REF_CLK_IN);
   endclocking
   default disable iff (!RSTN_IN);

   // Rule checks on the registered state; writes are excluded where software may override.

   AST_WAKE_EDGE: assert property (
      (st_ff.wake_en && !st_ff.sync_mode && fall)
         |=> (!st_ff.wake_en && st_ff.irq_sts[`SBRG_EV_WAKE]))
      else $error("Wake edge did not set the flag and clear the enable.");
   AST_ABD_DONE: assert property (
      (st_ff.abd == sbrg_pkg::SBRG_ABD_MEAS && rise && st_ff.abd_en && !st_ff.sync_mode
       && !wr_now)
         |=> (!st_ff.abd_en && st_ff.irq_sts[`SBRG_EV_ABD] && st_ff.cnt == 16'h0000))
      else $error("Auto-rate detect did not finish and clear its enable.");
   AST_SYNC_NO_EFFECT: assert property (
      (st_ff.sync_mode && !wr_now) |=> (st_ff.abd == sbrg_pkg::SBRG_ABD_IDLE)
         && ($stable(st_ff.wake_en)))
      else $error("Enables acted in synchronous mode.");
   AST_SYNC_TICK: assert property (
      (st_ff.sync_mode && step && st_ff.cnt >= lim) |=> BIT_TICK_OUT)
      else $error("Synchronous mode produced no bit tick.");
   AST_NARROW: assert property (
      (!st_ff.wide && step && st_ff.cnt[15:8] != 8'h00) |=> st_ff.cnt == 16'h0000)
      else $error("Narrow timer counted past eight bits.");
   AST_PERIOD: assert property (
      (step && st_ff.cnt == {st_ff.div_hi, st_ff.div_lo} && st_ff.wide)
         |=> (BIT_TICK_OUT && st_ff.cnt == 16'h0000))
      else $error("Timer did not wrap at the divisor pair.");
   AST_PRE_ASYNC: assert property (
      (!st_ff.sync_mode && !st_ff.chg && step)
         |-> st_ff.pre == (st_ff.wide ? (st_ff.high_speed ? 6'h03 : 6'h0F)
                                      : (st_ff.high_speed ? 6'h0F : 6'h3F)))
      else $error("Asynchronous multiplier is wrong.");
   AST_GAP_SYNC: assert property (
      (BIT_TICK_OUT && st_ff.seen && !st_ff.chg && st_ff.sync_mode)
         |-> st_ff.gap == 23'(4 * ({7'h00, lim} + 23'h000001)))
      else $error("Synchronous bit period is not four times n plus one.");
   AST_DIV_CLR: assert property (
      (wr_now && (st_ff.ap_addr == `SBRG_ADDR_DLO || st_ff.ap_addr == `SBRG_ADDR_DHI))
         |=> (st_ff.cnt == 16'h0000 && st_ff.pre == 6'h00))
      else $error("Divisor write did not clear the timer.");
   AST_GAP_NORM: assert property (
      (BIT_TICK_OUT && st_ff.seen && !st_ff.chg && !st_ff.sync_mode && !st_ff.high_speed)
         |-> st_ff.gap == 23'((st_ff.wide ? 16 : 64) * ({7'h00, lim} + 23'h000001)))
      else $error("Normal-speed bit period is wrong.");
   AST_GAP_HS: assert property (
      (BIT_TICK_OUT && st_ff.seen && !st_ff.chg && !st_ff.sync_mode && st_ff.high_speed)
         |-> st_ff.gap == 23'((st_ff.wide ? 4 : 16) * ({7'h00, lim} + 23'h000001)))
      else $error("High-speed bit period is wrong.");
   AST_PRE_SYNC: assert property (
      (st_ff.sync_mode && !st_ff.chg && step) |-> st_ff.pre == 6'h03)
      else $error("Synchronous multiplier is not four.");
   AST_TICK_SPACED: assert property (
      BIT_TICK_OUT |=> !BIT_TICK_OUT)
      else $error("Bit tick lasted more than one cycle.");

   // Hold checks: enables and divisor bytes move only on their own events or a write.
   AST_WAKE_HOLD: assert property (
      (!fall && !wr_now) |=> $stable(st_ff.wake_en))
      else $error("Wake enable changed without an edge or a write.");
   AST_ABD_HOLD: assert property (
      (!rise && !wr_now) |=> $stable(st_ff.abd_en))
      else $error("Auto-rate enable changed without an end of measurement or a write.");
   AST_ABD_LOAD: assert property (
      (st_ff.abd == sbrg_pkg::SBRG_ABD_MEAS && rise && st_ff.abd_en && !st_ff.sync_mode
       && !wr_now && !st_ff.wide && st_ff.abd_cnt != 16'h0000 && st_ff.abd_cnt <= 16'h0100)
         |=> ({8'h00, st_ff.div_lo} + 16'h0001 == st_ff.abd_cnt))
      else $error("Measured start bit did not load the divisor.");
   AST_DIV_HI_KEEP: assert property (
      (st_ff.abd == sbrg_pkg::SBRG_ABD_MEAS && rise && st_ff.abd_en && !st_ff.sync_mode
       && !wr_now && !st_ff.wide)
         |=> $stable(st_ff.div_hi))
      else $error("Narrow measurement changed the high divisor byte.");

   COV_SYNC_TICK: cover property (st_ff.sync_mode && BIT_TICK_OUT);
   COV_WAKE: cover property ($rose(st_ff.irq_sts[`SBRG_EV_WAKE]));
   COV_ABD: cover property ($rose(st_ff.irq_sts[`SBRG_EV_ABD]));
   COV_WIDE_TICK: cover property (st_ff.wide && st_ff.seen && !st_ff.chg && BIT_TICK_OUT);
   COV_HS_TICK: cover property (st_ff.high_speed && !st_ff.sync_mode && BIT_TICK_OUT);
endmodule : sbrg_top

// >>> tb/sbrg_rx_model.sv
// Remote serial transmitter model that drives the receive pin.
`timescale 1ns/1ps
module sbrg_rx_model (
   input wire logic clk_in,
   input wire logic go_in,
   input wire logic [15:0] low_in,
   output logic rx_out
);
   logic [15:0] left_ff = 16'h0000;
   // A start request pulls the line low for low_in cycles; the line idles high between frames.
   always_ff @(posedge clk_in) begin
      if (go_in) begin
         left_ff <= low_in;
      end else if (left_ff != 16'h0000) begin
         left_ff <= left_ff - 16'h0001;
      end
   end
   // Low pulse width stands in for one start bit of a remote character.
   assign rx_out = (left_ff == 16'h0000);
endmodule : sbrg_rx_model

// >>> tb/sbrg_top_test.sv
// Self-checking bench for the serial rate generator.
`timescale 1ns/1ps
`include "sbrg_consts.svh"
module sbrg_top_test;
   logic clk = 1'b0;
   logic rstn = 1'b0;
   logic [31:0] haddr = 32'h0000_0000;
   logic [1:0] htrans = 2'h0;
   logic hwrite = 1'b0;
   logic [31:0] hwdata = 32'h0000_0000;
   logic [31:0] hrdata;
   logic hready;
   logic hresp;
   logic rsp;
   logic irq;
   logic tick;
   logic rx;
   logic go = 1'b0;
   logic [15:0] low = 16'h0000;
   logic [31:0] rd;
   int err_count = 0;
   int n_checks = 0;
   int cnt;
   logic [7:0] tv [6] = '{8'h00, 8'h04, 8'h00, 8'h04, 8'h14, 8'h10};
   logic [7:0] cv [6] = '{8'h00, 8'h00, 8'h08, 8'h08, 8'h00, 8'h08};
   int ev [6] = '{192, 48, 4144, 1036, 12, 1036};

   sbrg_top u_sbrg_top (.REF_CLK_IN(clk), .RSTN_IN(rstn), .HSEL_IN(1'b1), .HADDR_IN(haddr),
      .HTRANS_IN(htrans), .HWRITE_IN(hwrite), .HSIZE_IN(3'h2), .HWDATA_IN(hwdata),
      .HREADY_IN(hready), .RX_IN(rx), .HRDATA_OUT(hrdata), .HREADYOUT_OUT(hready),
      .HRESP_OUT(hresp), .IRQ_OUT(irq), .BIT_TICK_OUT(tick));
   sbrg_rx_model u_sbrg_rx_model (.clk_in(clk), .go_in(go), .low_in(low), .rx_out(rx));

   // Free running 100 MHz clock.
   initial begin
      forever #5 clk = ~clk;
   end

   // One single AHB-Lite word transfer; read data is taken at the data phase edge.
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
      haddr <= {24'h00_0000, a};
      hwrite <= w;
      htrans <= 2'h2;
      @(posedge clk);
      while (hready !== 1'b1) @(posedge clk);
      htrans <= 2'h0;
      hwdata <= d;
      @(posedge clk);
      while (hready !== 1'b1) @(posedge clk);
      rd = hrdata;
      rsp = hresp;
   endtask : bus

   task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
      n_checks++;
      if (got !== exp) begin
         err_count++;
         $display("unexpected %s: expected %h, seen %h", nm, exp, got);
      end
   endtask : chk

   task automatic rdc(input logic [7:0] a, input logic [31:0] exp, input string nm);
      bus(1'b0, a, 32'h0000_0000);
      chk(nm, exp, rd);
      chk("response", 0, rsp);
   endtask : rdc

   // Counts edges until the next bit tick; the bound keeps a dead timer from hanging the run.
   task automatic wtk(output int n);
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (tick !== 1'b1 && n < 20000);
   endtask : wtk

   // Sends one low pulse from the remote side, then lets the line settle.
   task automatic pulse(input logic [15:0] len);
      go <= 1'b1;
      low <= len;
      @(posedge clk);
      go <= 1'b0;
      repeat (len + 16'h0028) @(posedge clk);
   endtask : pulse

   task automatic finish_test;
      $display("checks %0d, errors %0d", n_checks, err_count);
      if (err_count == 0 && n_checks > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask : finish_test

   // Hang guard, well beyond the expected length of all tests.
   initial begin
      repeat (60000) @(posedge clk);
      err_count++;
      finish_test();
   end

   initial begin
      repeat (20) @(posedge clk);
      rstn <= 1'b1;
      @(posedge clk);
      wtk(cnt);
      wtk(cnt);
      chk("reset period", 64, cnt);
      bus(1'b1, 8'h18, 32'h0000_00FF);
      for (int i = 0; i < 7; i++) begin
         rdc(8'(4 * i), (i == 0) ? 32'h0000_0040 : 32'h0000_0000, "reset value");
      end
      bus(1'b1, `SBRG_ADDR_MSK, 32'h0000_0003);
      rdc(`SBRG_ADDR_MSK, 32'h0000_0003, "mask");
      // Every multiplier choice, with the high byte ignored in narrow mode.
      for (int i = 0; i < 6; i++) begin
         bus(1'b1, `SBRG_ADDR_TCS, {24'h00_0000, tv[i]});
         bus(1'b1, `SBRG_ADDR_CTRL, {24'h00_0000, cv[i]});
         bus(1'b1, `SBRG_ADDR_DHI, 32'h0000_0001);
         bus(1'b1, `SBRG_ADDR_DLO, 32'h0000_0002);
         wtk(cnt);
         wtk(cnt);
         chk("period", ev[i], cnt);
      end
      // A divisor rewrite in mid-period restarts the count.
      bus(1'b1, `SBRG_ADDR_TCS, 32'h0000_0000);
      bus(1'b1, `SBRG_ADDR_CTRL, 32'h0000_0000);
      bus(1'b1, `SBRG_ADDR_DLO, 32'h0000_0003);
      wtk(cnt);
      repeat (150) @(posedge clk);
      bus(1'b1, `SBRG_ADDR_DLO, 32'h0000_0003);
      wtk(cnt);
      chk("restart", 1, (cnt >= 250 && cnt <= 262));
      // Wake on falling edge in asynchronous mode.
      bus(1'b1, `SBRG_ADDR_MSK, 32'h0000_0001);
      bus(1'b1, `SBRG_ADDR_CTRL, 32'h0000_0002);
      pulse(16'h0028);
      chk("irq", 1, irq);
      rdc(`SBRG_ADDR_STS, 32'h0000_0001, "status");
      rdc(`SBRG_ADDR_CTRL, 32'h0000_0040, "control");
      bus(1'b1, `SBRG_ADDR_STS, 32'h0000_0001);
      rdc(`SBRG_ADDR_STS, 32'h0000_0000, "status");
      chk("irq", 0, irq);
      // Synchronous mode ignores the wake enable and keeps it.
      bus(1'b1, `SBRG_ADDR_TCS, 32'h0000_0010);
      bus(1'b1, `SBRG_ADDR_CTRL, 32'h0000_0002);
      pulse(16'h0028);
      rdc(`SBRG_ADDR_STS, 32'h0000_0000, "status");
      rdc(`SBRG_ADDR_CTRL, 32'h0000_0042, "control");
      // Back to asynchronous with the event masked.
      bus(1'b1, `SBRG_ADDR_MSK, 32'h0000_0000);
      bus(1'b1, `SBRG_ADDR_TCS, 32'h0000_0000);
      pulse(16'h0028);
      chk("irq", 0, irq);
      rdc(`SBRG_ADDR_STS, 32'h0000_0001, "status");
      bus(1'b1, `SBRG_ADDR_MSK, 32'h0000_0003);
      repeat (2) @(posedge clk);
      chk("irq", 1, irq);
      bus(1'b1, `SBRG_ADDR_STS, 32'h0000_0001);
      // Auto rate detect over a start bit of six steps of 64 clocks.
      bus(1'b1, `SBRG_ADDR_DLO, 32'h0000_0000);
      bus(1'b1, `SBRG_ADDR_CTRL, 32'h0000_0001);
      // The idle flag must read low while the start bit is being measured.
      go <= 1'b1;
      low <= 16'd384;
      @(posedge clk);
      go <= 1'b0;
      repeat (100) @(posedge clk);
      rdc(`SBRG_ADDR_CTRL, 32'h0000_0001, "receiving");
      repeat (330) @(posedge clk);
      rdc(`SBRG_ADDR_STS, 32'h0000_0002, "status");
      rdc(`SBRG_ADDR_CTRL, 32'h0000_0040, "control");
      bus(1'b0, `SBRG_ADDR_DLO, 32'h0000_0000);
      chk("measured", 1, (rd >= 32'h4 && rd <= 32'h6));
      chk("irq", 1, irq);
      bus(1'b1, `SBRG_ADDR_STS, 32'h0000_0002);
      rdc(`SBRG_ADDR_STS, 32'h0000_0000, "status");
      finish_test();
   end
endmodule : sbrg_top_test
